// ==== rtl/hdd_display.sv ====
// Diagnostic front-panel display and button sequencer for the servo drive
`timescale 1ns/10ps
// Notes on behaviour
// [RULE_01] Normally show operating state; init for Start, nrdy for Not Ready.
// [RULE_02] Show StoP in quick stop; FLE for fault reaction and fault (the code shows FLt).
// [RULE_03] External panel connected: show its message, ignore the button.
// [RULE_04] Show card message when memory card differs from drive settings.
// [RULE_05] Show Prot when the panel lock setting locks functions.
// [RULE_06] Show uLoW when controller supply is low during initialization.
// [RULE_07] Show WdoG on an unidentified internal system error.
// [RULE_08] New motor: show message, press shows SAVE, press saves, goes to state 4.
// [RULE_09] Class 0 error pending: flash right dots, hide the error code.
// [RULE_10] Class 0: code while held, reset prompt on release, press clears.
// [RULE_11] Cancelling the class 0 reset keeps the error pending.
// [RULE_12] Class 1 error: alternate error code and stop message.
// [RULE_13] Class 2 to 4 error: alternate error code and fault message.
// [RULE_14] Class 1 to 4: press shows reset prompt, press clears, state 4.
// [RULE_15] Debounce the button; one event per press; hold differs from tap.
module hdd_display #(
    parameter int unsigned DEBOUNCE_CYCLES = hdd_pkg::DEBOUNCE_CYC,
    parameter int unsigned HOLD_CYCLES     = hdd_pkg::HOLD_CYC,
    parameter int unsigned BLINK_CYCLES    = hdd_pkg::BLINK_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   button_i,
    input  wire hdd_pkg::hdd_status_type status_i,
    output logic                        cancel_i_unused_o,
    output hdd_pkg::hdd_disp_type       disp_o,
    output hdd_pkg::hdd_req_type        req_o
);
    import hdd_pkg::*;

    // Refuse timings the counters cannot serve
    if (DEBOUNCE_CYCLES < 1 || HOLD_CYCLES <= DEBOUNCE_CYCLES
            || BLINK_CYCLES < 1) begin : g_bad_timing
        $error("hdd_display: timing parameters out of range");
    end

    // ------------------------------------------------------------
    // Button debounce and press classification
    // ------------------------------------------------------------
    logic [31:0] deb_cnt_q;
    logic [31:0] hold_cnt_q;
    logic        btn_q;
    logic        held_q;
    wire  logic  btn_change = (button_i != btn_q);
    wire  logic  press_ev   = btn_change && !btn_q &&
                              (deb_cnt_q == 32'(DEBOUNCE_CYCLES - 1));
    wire  logic  release_ev = btn_change && btn_q &&
                              (deb_cnt_q == 32'(DEBOUNCE_CYCLES - 1));
    wire  logic  hold_ev    = btn_q && !held_q &&
                              (hold_cnt_q == 32'(HOLD_CYCLES - 1));

    // Input must stay stable a full window before the state flips
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            deb_cnt_q <= 32'h0;
            btn_q     <= 1'b0;
        end else if (!btn_change) begin
            deb_cnt_q <= 32'h0;
        end else if (deb_cnt_q == 32'(DEBOUNCE_CYCLES - 1)) begin
            deb_cnt_q <= 32'h0;
            btn_q     <= button_i; // RULE_15
        end else begin
            deb_cnt_q <= deb_cnt_q + 32'h1;
        end
    end

    // Hold timer, fires once per press
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_cnt_q <= 32'h0;
            held_q     <= 1'b0;
        end else if (!btn_q) begin
            hold_cnt_q <= 32'h0;
            held_q     <= 1'b0;
        end else if (hold_ev) begin
            held_q     <= 1'b1; // RULE_15
        end else if (!held_q) begin
            hold_cnt_q <= hold_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Blink timer for alternation and dot flashing
    // ------------------------------------------------------------
    logic [31:0] blink_cnt_q;
    logic        phase_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            blink_cnt_q <= 32'h0;
            phase_q     <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_q <= 32'h0;
            phase_q     <= !phase_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Button sequence state machine
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE      = 6'b000001,
        ST_SAVE      = 6'b000010,
        ST_W0_SHOW   = 6'b000100,
        ST_W0_PROMPT = 6'b001000,
        ST_ERR_PROMPT= 6'b010000,
        ST_W0_WAIT   = 6'b100000
    } hdd_seq_type;

    hdd_seq_type seq_q;
    hdd_seq_type seq_d;
    hdd_req_type req_d;

    // External panel disables all button handling
    wire logic btn_ok      = !status_i.ext_panel; // RULE_03
    wire logic p_ev        = press_ev && btn_ok;
    wire logic err_hi      = status_i.err_pending && (status_i.err_class != ECLASS_WARN)
                             && (status_i.err_class <= ECLASS_MAX);
    wire logic err_warn    = status_i.err_pending && (status_i.err_class == ECLASS_WARN);

    always_comb begin
        seq_d = seq_q;
        req_d = REQ_NONE;
        case (seq_q)
            ST_IDLE: begin
                if (p_ev && err_hi) begin
                    seq_d = ST_ERR_PROMPT; // RULE_14
                end else if (p_ev && status_i.motor_new) begin
                    seq_d = ST_SAVE; // RULE_08
                end else if (p_ev && err_warn) begin
                    seq_d = ST_W0_WAIT;
                end
            end
            ST_W0_WAIT: begin
                // Short tap before hold timer expires cancels, error kept
                if (hold_ev) begin
                    seq_d = ST_W0_SHOW; // RULE_10
                end else if (release_ev || !btn_ok) begin
                    seq_d = ST_IDLE; // RULE_11
                end
            end
            ST_W0_SHOW: begin
                if (release_ev) begin
                    seq_d = ST_W0_PROMPT; // RULE_10
                end else if (!btn_ok) begin
                    seq_d = ST_IDLE;
                end
            end
            ST_W0_PROMPT: begin
                if (hold_ev || !btn_ok || !err_warn) begin
                    seq_d = ST_IDLE; // RULE_11
                end else if (release_ev) begin
                    seq_d = ST_IDLE;
                    req_d.clear_error = 1'b1; // RULE_10
                end
            end
            ST_SAVE: begin
                if (hold_ev || !btn_ok || !status_i.motor_new) begin
                    seq_d = ST_IDLE;
                end else if (p_ev) begin
                    seq_d = ST_IDLE;
                    req_d.save_motor = 1'b1; // RULE_08
                    req_d.goto_ready = 1'b1; // RULE_08
                end
            end
            ST_ERR_PROMPT: begin
                if (hold_ev || !btn_ok || !err_hi) begin
                    seq_d = ST_IDLE;
                end else if (p_ev) begin
                    seq_d = ST_IDLE;
                    req_d.clear_error = 1'b1; // RULE_14
                    req_d.goto_ready  = 1'b1; // RULE_14
                end
            end
            default: begin
                seq_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Display content selection
    // ------------------------------------------------------------
    function automatic hdd_text_type code_text(input logic [15:0] code);
        code_text = '{{1'b0, code[15:12]}, {1'b0, code[11:8]},
                      {1'b0, code[7:4]}, {1'b0, code[3:0]}};
    endfunction

    function automatic hdd_text_type state_text(input logic [3:0] st);
        case (st)
            OPST_START:       state_text = '{CH_I, CH_N, CH_I, CH_T};
            OPST_NOT_READY:   state_text = '{CH_N, CH_R, CH_D, CH_Y};
            OPST_SW_DISABLED: state_text = '{CH_BLANK, CH_D, CH_I, CH_S};
            OPST_READY:       state_text = '{CH_BLANK, CH_R, CH_D, CH_Y};
            OPST_SWITCHED_ON: state_text = '{CH_BLANK, CH_S, CH_O, CH_N};
            OPST_OP_ENABLED:  state_text = '{CH_BLANK, CH_R, CH_U, CH_N};
            OPST_QUICK_STOP:  state_text = '{CH_S, CH_T, CH_O, CH_P};
            OPST_FAULT_REACT,
            OPST_FAULT:       state_text = '{CH_BLANK, CH_F, CH_L, CH_T};
            default:          state_text = TXT_BLANK;
        endcase
    endfunction

    wire hdd_text_type err_code_txt = code_text(status_i.err_code);
    wire hdd_text_type stop_txt     = '{CH_BLANK, CH_S, CH_T, CH_P};
    wire hdd_text_type flt_txt      = '{CH_BLANK, CH_F, CH_L, CH_T};
    wire hdd_text_type fres_txt     = '{CH_F, CH_R, CH_E, CH_S};
    wire hdd_text_type save_txt     = '{CH_S, CH_A, CH_V, CH_E};
    wire hdd_text_type alt_txt      = (status_i.err_class == ECLASS_STOP) ? stop_txt : flt_txt;
    hdd_text_type text_d;

    // Priority: system states, sequences, errors, notices, operating state
    always_comb begin
        if (status_i.ext_panel) begin
            text_d = '{CH_D, CH_I, CH_S, CH_P}; // RULE_03
        end else if (status_i.sys_error) begin
            text_d = '{CH_W, CH_D, CH_O, CH_G}; // RULE_07
        end else if (status_i.supply_low && status_i.op_state == OPST_START) begin
            text_d = '{CH_U, CH_L, CH_O, CH_W}; // RULE_06
        end else if (seq_q == ST_SAVE) begin
            text_d = save_txt; // RULE_08
        end else if (seq_q == ST_ERR_PROMPT || seq_q == ST_W0_PROMPT) begin
            text_d = fres_txt; // RULE_14
        end else if (seq_q == ST_W0_SHOW) begin
            text_d = err_code_txt; // RULE_10
        end else if (err_hi) begin
            text_d = phase_q ? alt_txt : err_code_txt; // RULE_12 RULE_13
        end else if (status_i.motor_new) begin
            text_d = '{CH_BLANK, CH_M, CH_O, CH_T}; // RULE_08
        end else if (status_i.card_mismatch) begin
            text_d = '{CH_C, CH_A, CH_R, CH_D}; // RULE_04
        end else if (status_i.panel_lock_setting) begin
            text_d = '{CH_P, CH_R, CH_O, CH_T}; // RULE_05
        end else begin
            text_d = state_text(status_i.op_state); // RULE_01 RULE_02
        end
    end

    // Dots flash only; the class 0 code stays hidden until queried
    wire logic [1:0] dots_d = (err_warn && phase_q) ? 2'b11 : 2'b00; // RULE_09

    // ------------------------------------------------------------
    // Registered state and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_q  <= ST_IDLE;
            req_o  <= REQ_NONE;
            disp_o <= '{TXT_BLANK, 2'b00};
        end else begin
            seq_q  <= seq_d;
            req_o  <= req_d;
            disp_o <= '{text_d, dots_d};
        end
    end

    // Status bit pulses for one cycle when a tap cancels the class 0 query
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cancel_i_unused_o <= 1'b0;
        end else begin
            // Only an operator tap cancels; a panel takeover leaves silently
            cancel_i_unused_o <= (seq_q == ST_W0_WAIT) && release_ev && !hold_ev
                                 && btn_ok; // RULE_11
        end
    end

endmodule

// ==== rtl/hdd_pkg.sv ====
// Package: constants, character codes and types for the diagnostic display
package hdd_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 5;
    localparam int unsigned DEBOUNCE_MS      = 20;
    localparam int unsigned HOLD_MS          = 500;
    localparam int unsigned BLINK_MS         = 500;
    localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYC         = HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned BLINK_CYC        = BLINK_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Operating states and error classes
    // ------------------------------------------------------------
    localparam logic [3:0] OPST_START        = 4'h1;
    localparam logic [3:0] OPST_NOT_READY    = 4'h2;
    localparam logic [3:0] OPST_SW_DISABLED  = 4'h3;
    localparam logic [3:0] OPST_READY        = 4'h4;
    localparam logic [3:0] OPST_SWITCHED_ON  = 4'h5;
    localparam logic [3:0] OPST_OP_ENABLED   = 4'h6;
    localparam logic [3:0] OPST_QUICK_STOP   = 4'h7;
    localparam logic [3:0] OPST_FAULT_REACT  = 4'h8;
    localparam logic [3:0] OPST_FAULT        = 4'h9;
    localparam logic [2:0] ECLASS_WARN       = 3'h0;
    localparam logic [2:0] ECLASS_STOP       = 3'h1;
    localparam logic [2:0] ECLASS_MAX        = 3'h4;

    // ------------------------------------------------------------
    // Character codes: 0..f are hex digits, 5'h10 is blank, others letters
    // ------------------------------------------------------------
    localparam logic [4:0] CH_A     = 5'h0a;
    localparam logic [4:0] CH_C     = 5'h0c;
    localparam logic [4:0] CH_D     = 5'h0d;
    localparam logic [4:0] CH_E     = 5'h0e;
    localparam logic [4:0] CH_F     = 5'h0f;
    localparam logic [4:0] CH_BLANK = 5'h10;
    localparam logic [4:0] CH_G     = 5'h11;
    localparam logic [4:0] CH_I     = 5'h12;
    localparam logic [4:0] CH_L     = 5'h13;
    localparam logic [4:0] CH_N     = 5'h14;
    localparam logic [4:0] CH_O     = 5'h15;
    localparam logic [4:0] CH_P     = 5'h16;
    localparam logic [4:0] CH_R     = 5'h17;
    localparam logic [4:0] CH_S     = 5'h18;
    localparam logic [4:0] CH_T     = 5'h19;
    localparam logic [4:0] CH_U     = 5'h1a;
    localparam logic [4:0] CH_W     = 5'h1b;
    localparam logic [4:0] CH_Y     = 5'h1c;
    localparam logic [4:0] CH_H     = 5'h1d;
    localparam logic [4:0] CH_V     = 5'h1e;
    localparam logic [4:0] CH_M     = 5'h1f;

    // Four characters, leftmost first
    typedef struct packed {
        logic [4:0] c3;
        logic [4:0] c2;
        logic [4:0] c1;
        logic [4:0] c0;
    } hdd_text_type;

    // Display output: text plus the two right-hand dots
    typedef struct packed {
        hdd_text_type text;
        logic [1:0]   dots;
    } hdd_disp_type;

    // Status from the drive side
    typedef struct packed {
        logic [3:0]  op_state;
        logic        err_pending;
        logic [2:0]  err_class;
        logic [15:0] err_code;
        logic        ext_panel;
        logic        card_mismatch;
        logic        motor_new;
        logic        panel_lock_setting;
        logic        supply_low;
        logic        sys_error;
    } hdd_status_type;

    // Requests to the drive side, one-cycle pulses
    typedef struct packed {
        logic save_motor;
        logic clear_error;
        logic goto_ready;
    } hdd_req_type;

    localparam hdd_text_type TXT_BLANK = '{CH_BLANK, CH_BLANK, CH_BLANK, CH_BLANK};
    localparam hdd_req_type  REQ_NONE  = '{1'b0, 1'b0, 1'b0};

endpackage

// ==== verification/hdd_display_properties.sv ====
// Checker: port-level properties of the diagnostic display
`timescale 1ns/10ps
module hdd_display_properties
    import hdd_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = 8
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           button_i,
    input  wire hdd_status_type status_i,
    input  wire logic           cancel_i_unused_o,
    input  wire hdd_disp_type   disp_o,
    input  wire hdd_req_type    req_o
);
    // ------------------------------------------------------------
    // Clocking and helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    localparam int BLW = 2 * BLINK_CYCLES + 2;
    // Class 0 warning pending
    wire logic c0 = status_i.err_pending && (status_i.err_class == ECLASS_WARN);
    sequence s_ext2;
        status_i.ext_panel [*2];
    endsequence
    sequence s_c0;
        c0 [*2];
    endsequence
    // Cycles the dots stayed dark while a class 0 warning is pending
    logic [31:0] dark_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dark_q <= 32'h0;
        end else if (!c0 || disp_o.dots == 2'b11) begin
            dark_q <= 32'h0;
        end else begin
            dark_q <= dark_q + 32'h1;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ext_text;
        status_i.ext_panel |=> disp_o.text == {CH_D, CH_I, CH_S, CH_P};
    endproperty
    property p_ext_quiet;
        s_ext2 |-> (req_o == REQ_NONE) && !cancel_i_unused_o;
    endproperty
    property p_wdog;
        status_i.sys_error && !status_i.ext_panel |=> disp_o.text == {CH_W, CH_D, CH_O, CH_G};
    endproperty
    property p_ulow;
        status_i.supply_low && status_i.op_state == OPST_START && !status_i.sys_error
            && !status_i.ext_panel |=> disp_o.text == {CH_U, CH_L, CH_O, CH_W};
    endproperty
    property p_save;
        req_o.save_motor |-> req_o.goto_ready;
    endproperty
    property p_pulse;
        req_o.clear_error |=> !req_o.clear_error;
    endproperty
    property p_dots_on;
        s_c0 |-> dark_q <= 32'(BLW);
    endproperty
    property p_dots_off;
        !status_i.err_pending [*2] |-> disp_o.dots == 2'b00;
    endproperty
    property p_cancel;
        cancel_i_unused_o |-> !req_o.clear_error && !req_o.goto_ready;
    endproperty
    a_ext_text:  assert property (p_ext_text)  else $error("panel text wrong");
    a_ext_quiet: assert property (p_ext_quiet) else $error("button not ignored");
    a_wdog:      assert property (p_wdog)      else $error("system error text wrong");
    a_ulow:      assert property (p_ulow)      else $error("low supply text wrong");
    a_save:      assert property (p_save)      else $error("save without ready");
    a_pulse:     assert property (p_pulse)     else $error("clear longer than a cycle");
    a_dots_on:   assert property (p_dots_on)   else $error("dots never lit");
    a_dots_off:  assert property (p_dots_off)  else $error("dots lit without error");
    a_cancel:    assert property (p_cancel)    else $error("cancel also cleared");
endmodule

bind hdd_display hdd_display_properties #(.BLINK_CYCLES(BLINK_CYCLES)) hdd_display_properties_i (
    .clk_i(clk_i), .rst_i(rst_i), .button_i(button_i), .status_i(status_i),
    .cancel_i_unused_o(cancel_i_unused_o), .disp_o(disp_o), .req_o(req_o));

// ==== verification/hdd_operator.sv ====
// Operator model: presses and releases the navigation button
`timescale 1ns/10ps
module hdd_operator #(
    parameter int unsigned SETTLE = 7
) (
    input  wire logic clk_i,
    output logic      button_o
);
    initial button_o = 1'b0;
    // Contact bounce before each new level, shorter than the debounce
    task automatic set_level(input logic lvl);
        @(posedge clk_i);
        #1 button_o = lvl;
        @(posedge clk_i);
        #1 button_o = !lvl;
        @(posedge clk_i);
        #1 button_o = lvl;
        repeat (SETTLE) @(posedge clk_i);
        #1;
    endtask
    // Press always precedes release
    task automatic press();
        set_level(1'b1);
    endtask
    // Named lift, since the plain word for letting go is a language keyword
    task automatic lift();
        set_level(1'b0);
    endtask
endmodule

// ==== verification/tb_hdd_display.sv ====
// Testbench: display texts and button sequences of the diagnostic display
`timescale 1ns/10ps
module tb_hdd_display;
    import hdd_pkg::*;
    localparam int unsigned DEB = 4;
    localparam int unsigned HLD = 20;
    localparam int unsigned BLK = 8;
    localparam hdd_text_type RDY  = {CH_BLANK, CH_R, CH_D, CH_Y};
    localparam hdd_text_type FRES = {CH_F, CH_R, CH_E, CH_S};
    logic           clk_i = 1'b0;
    logic           rst_i = 1'b1;
    logic           button;
    logic           cancel;
    hdd_status_type st = '0;
    hdd_disp_type   disp;
    hdd_req_type    req;
    int n_fail = 0, checks_done = 0, n_save = 0, n_clear = 0, n_ready = 0, n_cancel = 0;

    always #2.5 clk_i = ~clk_i;
    hdd_display #(.DEBOUNCE_CYCLES(DEB), .HOLD_CYCLES(HLD), .BLINK_CYCLES(BLK)) hdd_display_i (
        .clk_i(clk_i), .rst_i(rst_i), .button_i(button), .status_i(st),
        .cancel_i_unused_o(cancel), .disp_o(disp), .req_o(req));
    hdd_operator #(.SETTLE(DEB + 3)) hdd_operator_i (.clk_i(clk_i), .button_o(button));

    // Count request pulses once their edge has settled
    always @(posedge clk_i) begin
        #1;
        if (req.save_motor === 1'b1) n_save++;
        if (req.clear_error === 1'b1) n_clear++;
        if (req.goto_ready === 1'b1) n_ready++;
        if (cancel === 1'b1) n_cancel++;
    end
    // ------------------------------------------------------------
    // Shared checks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait, so a stuck display fails instead of hanging
    task automatic wait_txt(input hdd_text_type exp);
        for (int k = 0; k < 60; k++) begin
            if (disp.text === exp) break;
            @(posedge clk_i);
            #1;
        end
        chk(32'(disp.text), 32'(exp));
    endtask
    task automatic tap();
        hdd_operator_i.press();
        hdd_operator_i.lift();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_states();
        st.op_state = OPST_START;
        wait_txt({CH_I, CH_N, CH_I, CH_T});
        st.op_state = OPST_NOT_READY;
        wait_txt({CH_N, CH_R, CH_D, CH_Y});
        st.op_state = OPST_QUICK_STOP;
        wait_txt({CH_S, CH_T, CH_O, CH_P});
        st.op_state = OPST_FAULT_REACT;
        wait_txt({CH_BLANK, CH_F, CH_L, CH_T});
        st.op_state = OPST_FAULT;
        wait_txt({CH_BLANK, CH_F, CH_L, CH_T});
    endtask
    // Show the card and Prot notices in turn, then raise uLoW, WdoG and the panel text in rising priority
    task automatic t_msgs();
        st.card_mismatch = 1'b1;
        wait_txt({CH_C, CH_A, CH_R, CH_D});
        st.card_mismatch = 1'b0;
        st.panel_lock_setting = 1'b1;
        wait_txt({CH_P, CH_R, CH_O, CH_T});
        st.panel_lock_setting = 1'b0;
        st.op_state = OPST_START;
        st.supply_low = 1'b1;
        wait_txt({CH_U, CH_L, CH_O, CH_W});
        st.sys_error = 1'b1;
        wait_txt({CH_W, CH_D, CH_O, CH_G});
        st.ext_panel = 1'b1;
        wait_txt({CH_D, CH_I, CH_S, CH_P});
        st = '0;
        st.op_state = OPST_READY;
    endtask
    task automatic t_motor();
        st.motor_new = 1'b1;
        st.ext_panel = 1'b1;
        tap();
        st.ext_panel = 1'b0;
        wait_txt({CH_BLANK, CH_M, CH_O, CH_T});
        chk(n_save, 0);
        hdd_operator_i.press();
        wait_txt({CH_S, CH_A, CH_V, CH_E});
        hdd_operator_i.lift();
        tap();
        chk(n_save, 1);
        chk(n_ready, 1);
        st.motor_new = 1'b0;
    endtask
    // Query, reset, then a cancelled query of a class 0 warning
    task automatic t_class0();
        st.err_pending = 1'b1;
        st.err_class = ECLASS_WARN;
        st.err_code = 16'h1a2b;
        repeat (2 * BLK) @(posedge clk_i);
        #1 chk(32'(disp.text), 32'(RDY));
        // Dots must light within one full blink period and two cycles
        for (int k = 0; k < 2 * BLK + 2 && disp.dots !== 2'b11; k++) begin
            @(posedge clk_i);
            #1;
        end
        chk(32'(disp.dots), 32'h3);
        hdd_operator_i.press();
        repeat (HLD + 2) @(posedge clk_i);
        #1 chk(32'(disp.text), {12'h000, 20'({5'h01, 5'h0a, 5'h02, 5'h0b})});
        hdd_operator_i.lift();
        wait_txt(FRES);
        tap();
        chk(n_clear, 1);
        st.err_pending = 1'b0;
        wait_txt(RDY);
        // Dots lag the pending flag by one registered cycle
        repeat (2) @(posedge clk_i);
        #1 chk(32'(disp.dots), 32'h0);
        st.err_pending = 1'b1;
        tap();
        chk(n_cancel, 1);
        chk(n_clear, 1);
        st.err_pending = 1'b0;
    endtask
    task automatic t_class();
        for (int c = 1; c <= 3; c += 2) begin
            st.err_class = 3'(c);
            st.err_code = 16'h3c4d;
            st.err_pending = 1'b1;
            wait_txt({5'h03, 5'h0c, 5'h04, 5'h0d});
            wait_txt(c == 1 ? {CH_BLANK, CH_S, CH_T, CH_P} : {CH_BLANK, CH_F, CH_L, CH_T});
            hdd_operator_i.press();
            wait_txt(FRES);
            hdd_operator_i.lift();
            tap();
            chk(n_clear, 32'(1 + (c + 1) / 2));
            chk(n_ready, 32'(1 + (c + 1) / 2));
            st.err_pending = 1'b0;
        end
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #60000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        #1 rst_i = 1'b0;
        t_states();
        t_msgs();
        t_motor();
        t_class0();
        t_class();
        conclude();
    end
endmodule
